// ### common/lsof_defines.svh
// constants of the lvds sample output formatter
`ifndef LSOF_DEFINES_SVH
`define LSOF_DEFINES_SVH

`define LSOF_LANES        16
`define LSOF_PAR_BITS     14
`define LSOF_SMP_W        32
`define LSOF_HALF_W       16
`define LSOF_FRAME_W      256
`define LSOF_FIFO_DEPTH   8
`define LSOF_PRBS_W       7
`define LSOF_PRBS_SEED    7'h7f
`define LSOF_L8_LOG2      5'h03
`define LSOF_S16_LOG2     4'h4
`define LSOF_LANE_L2_MAX  5'h04
`define LSOF_PAR_LAST     9'h001
`define LSOF_SUB_LANES    3

`endif

// ### common/lsof_pkg.sv
// types of the lvds sample output formatter
package lsof_pkg;
   typedef logic [1:0] lsof_bands_t;
   typedef logic [3:0] lsof_dec_t;

   typedef enum logic [1:0] {
      LSOF_SDR,
      LSOF_DDR,
      LSOF_SER
   } lsof_mode_t;

   typedef struct packed {
      logic        ddr;
      logic        res32;
      lsof_bands_t bands_l2;
      logic        cplx;
      lsof_dec_t   dec_l2;
      logic [2:0]  ovr_sel;
      logic [2:0]  scr_sel;
      logic        scr_en;
      logic        marker_en;
   } lsof_cfg_t;
endpackage

// ### logic/lsof_formatter.sv
// sample fifo and lvds output formatter (parallel sdr/ddr and serialized framing)
//
// What this block does
// - default parallel single-edge mode drives 14 sample bits, one per lane, on rising edge.
// - parallel double-edge mode drives data on rising half, zeros on falling half.
// - parallel formats are used only while decimation is bypassed.
// - any active decimation switches output to the serialized lane format.
// - parallel modes may put the overrange flag on lanes 0, 1 or 2.
// - parallel modes with scrambling may put the scramble bit on lanes 0, 1 or 2.
// - sample marker only on lane 0, and it beats overrange and scramble there.
// - serialized mode frames samples with the frame clock, data on both bit-clock edges.
// - serialized mode drives frame clock on lane 0, at most 15 data lanes.
// - serialized data starts on lane 15 and fills lanes downward.
// - real decimation supports a single band only; multi-band needs complex.
// - frame factor K is resolution code times band count times complex code.
// - lane count is 8 K over decimation; below one, a single lane is used.
// - one or more lanes: frame at fs/d, bit clock at fs, lane at 2 fs.
// - below one lane: lane at fs/d times 16K, bit clock at half lane rate.
// - frames go msb first, band 0 upward, in-phase before quadrature.
// - with 16 lanes, status bits may replace lsb+1 and lsb+2 positions.
// - with fewer lanes, status bits may replace lsb and lsb+1 of each sample.
// - scrambling xors every data bit with the prbs stream; receiver undoes it.
`timescale 1ns/1ps
`include "lsof_defines.svh"

// ****************************************
// sample fifo
// ****************************************
module lsof_fifo #(
   parameter int W     = `LSOF_SMP_W,
   parameter int DEPTH = `LSOF_FIFO_DEPTH
) (
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("fifo depth must be a power of two, at least two");
      end
   endgenerate

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0]   cnt_ff;
   logic [AW:0]   nxt_cnt;
   logic          ready_ff;
   logic          push;
   logic          pop;

   assign push        = i_in_valid & ready_ff;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_valid = (cnt_ff != '0);
   assign o_out_data  = mem[rd_ff];
   assign o_in_ready  = ready_ff;
   assign nxt_cnt     = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ff] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ff    <= '0;
         rd_ff    <= '0;
         cnt_ff   <= '0;
         ready_ff <= 1'b0;
      end else begin
         if (push) begin
            wr_ff <= AW'(wr_ff + 1'b1);
         end
         if (pop) begin
            rd_ff <= AW'(rd_ff + 1'b1);
         end
         cnt_ff   <= nxt_cnt;
         ready_ff <= (nxt_cnt != (AW+1)'(DEPTH));
      end
   end
endmodule

// ****************************************
// output formatter
// ****************************************
module lsof_formatter #(
   parameter int FIFO_DEPTH = `LSOF_FIFO_DEPTH
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_nrst,
   input  wire logic [`LSOF_SMP_W-1:0]  i_smp_data,
   input  wire logic                    i_smp_valid,
   output logic                         o_smp_ready,
   input  wire logic                    i_ddr_en,
   input  wire logic                    i_res32,
   input  wire lsof_pkg::lsof_bands_t   i_bands_l2,
   input  wire logic                    i_complex,
   input  wire lsof_pkg::lsof_dec_t     i_dec_l2,
   input  wire logic                    i_data_bit_clock_div_en,
   input  wire logic [2:0]              i_ovr_sel,
   input  wire logic [2:0]              i_scr_sel,
   input  wire logic                    i_scr_en,
   input  wire logic                    i_marker_en,
   input  wire logic                    i_overrange_flag,
   input  wire logic                    i_sample_marker,
   output logic [`LSOF_LANES-1:0]       o_lane,
   output logic                         o_data_bit_clock,
   output logic                         o_cfg_err,
   output logic                         o_underrun
);
   import lsof_pkg::*;

   // ****************************************
   // configuration and derived framing
   // ****************************************
   lsof_cfg_t                cfg_ff;
   lsof_cfg_t                nxt_cfg;
   lsof_mode_t               mode;
   lsof_bands_t              bands_eff;
   logic [2:0]               kl2;
   logic [4:0]               ll2_raw;
   logic                     ge1;
   logic [2:0]               lanes_l2;
   logic [3:0]               bpl_l2;
   logic [3:0]               div_l2;
   logic [8:0]               last_bit;
   logic [8:0]               half_bit;
   logic [12:0]              div_last;
   logic [3:0]               words_need;
   logic [8:0]               align_sh;
   logic [4:0]               lane_cnt;
   logic                     sub_hi;

   assign nxt_cfg = '{ddr: i_ddr_en, res32: i_res32, bands_l2: i_bands_l2, cplx: i_complex,
                      dec_l2: i_dec_l2, ovr_sel: i_ovr_sel, scr_sel: i_scr_sel,
                      scr_en: i_scr_en, marker_en: i_marker_en};

   always_comb begin
      if (cfg_ff.dec_l2 != '0) begin
         mode = LSOF_SER;
      end else if (cfg_ff.ddr) begin
         mode = LSOF_DDR;
      end else begin
         mode = LSOF_SDR;
      end
   end

   assign bands_eff  = cfg_ff.cplx ? cfg_ff.bands_l2 : '0;
   assign kl2        = 3'(cfg_ff.res32) + 3'(bands_eff) + 3'(cfg_ff.cplx);
   assign ge1        = ((`LSOF_L8_LOG2 + 5'(kl2)) >= 5'(cfg_ff.dec_l2));
   assign ll2_raw    = 5'(`LSOF_L8_LOG2 + 5'(kl2) - 5'(cfg_ff.dec_l2));
   assign lanes_l2   = !ge1 ? 3'h0 : (ll2_raw > `LSOF_LANE_L2_MAX) ? 3'(`LSOF_LANE_L2_MAX) : 3'(ll2_raw);
   assign bpl_l2     = 4'(`LSOF_S16_LOG2 + 4'(kl2) - 4'(lanes_l2));
   assign div_l2     = ge1 ? 4'h0 : 4'(cfg_ff.dec_l2 - 4'(`LSOF_L8_LOG2) - 4'(kl2));
   assign last_bit   = (mode == LSOF_SER) ? 9'((9'h001 << bpl_l2) - 9'h001) : `LSOF_PAR_LAST;
   assign half_bit   = 9'(9'h001 << (bpl_l2 - 4'h1));
   assign div_last   = 13'((13'h0001 << div_l2) - 13'h0001);
   assign words_need = 4'(4'h1 << (3'(bands_eff) + 3'(cfg_ff.cplx)));
   assign align_sh   = 9'(9'(`LSOF_FRAME_W) - 9'(9'(`LSOF_HALF_W) << kl2));
   assign lane_cnt   = 5'(5'h01 << lanes_l2);
   assign sub_hi     = (lanes_l2 == 3'(`LSOF_LANE_L2_MAX));

   // ****************************************
   // bit timing
   // ****************************************
   logic [12:0] div_ff;
   logic [8:0]  bitcnt_ff;
   logic        bit_en;
   logic        frame_start;
   logic        frame_end;

   assign bit_en      = (div_ff == '0);
   assign frame_start = bit_en & (bitcnt_ff == '0);
   assign frame_end   = bit_en & (bitcnt_ff == last_bit);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_ff    <= '0;
         bitcnt_ff <= '0;
      end else begin
         div_ff <= bit_en ? div_last : 13'(div_ff - 13'h0001);
         if (frame_end) begin
            bitcnt_ff <= '0;
         end else if (bit_en) begin
            bitcnt_ff <= 9'(bitcnt_ff + 9'h001);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_ff <= '0;
      end else if (frame_end) begin
         cfg_ff <= nxt_cfg;
      end
   end

   // ****************************************
   // sample intake, scrambling and substitution
   // ****************************************
   logic                     fifo_valid;
   logic [`LSOF_SMP_W-1:0]   fifo_data;
   logic                     fifo_pop;
   logic [`LSOF_PRBS_W-1:0]  prbs_ff;
   logic                     prbs_bit;
   logic [`LSOF_SMP_W-1:0]   word;
   logic [`LSOF_FRAME_W-1:0] acc_ff;
   logic [3:0]               words_ff;
   logic                     acc_full;
   logic                     cfg_change;

   lsof_fifo #(
      .W     (`LSOF_SMP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (i_smp_valid),
      .i_in_data   (i_smp_data),
      .o_in_ready  (o_smp_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (fifo_pop)
   );

   assign prbs_bit   = prbs_ff[`LSOF_PRBS_W-1];
   assign acc_full   = (words_ff == words_need);
   assign cfg_change = frame_end & (nxt_cfg != cfg_ff);
   assign fifo_pop   = (mode == LSOF_SER) ? (fifo_valid & !acc_full & !frame_start & !cfg_change)
                                          : (fifo_valid & frame_start);

   always_comb begin
      word = fifo_data;
      if (mode != LSOF_SER) begin
         word = word & `LSOF_SMP_W'({`LSOF_PAR_BITS{1'b1}});
      end else if (!cfg_ff.res32) begin
         word = word & `LSOF_SMP_W'({`LSOF_HALF_W{1'b1}});
      end
      if (cfg_ff.scr_en) begin
         word = word ^ {`LSOF_SMP_W{prbs_bit}};
      end
      if (mode == LSOF_SER) begin
         for (int k = 1; k < `LSOF_SUB_LANES; k++) begin
            if (cfg_ff.ovr_sel[k]) begin
               word[k - 1 + int'(sub_hi)] = i_overrange_flag;
            end else if (cfg_ff.scr_en && cfg_ff.scr_sel[k]) begin
               word[k - 1 + int'(sub_hi)] = prbs_bit;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prbs_ff <= `LSOF_PRBS_SEED;
      end else if (fifo_pop) begin
         prbs_ff <= {prbs_ff[`LSOF_PRBS_W-2:0], prbs_ff[`LSOF_PRBS_W-1] ^ prbs_ff[`LSOF_PRBS_W-2]};
      end
   end

   // samples arrive band 0 upward, in-phase then quadrature, and shift in below the older ones
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_ff   <= '0;
         words_ff <= '0;
      end else begin
         if (cfg_change || (frame_start && acc_full && mode == LSOF_SER)) begin
            words_ff <= '0;
         end else if (fifo_pop && mode == LSOF_SER) begin
            words_ff <= 4'(words_ff + 4'h1);
         end
         if (fifo_pop && mode == LSOF_SER) begin
            acc_ff <= cfg_ff.res32 ? {acc_ff[`LSOF_FRAME_W-`LSOF_SMP_W-1:0], word}
                                   : {acc_ff[`LSOF_FRAME_W-`LSOF_HALF_W-1:0], word[`LSOF_HALF_W-1:0]};
         end
      end
   end

   // ****************************************
   // lane mapping
   // ****************************************
   logic [`LSOF_FRAME_W-1:0] shreg_ff;
   logic [`LSOF_FRAME_W-1:0] src;
   logic [`LSOF_LANES-1:0]   ser_lane;
   logic [`LSOF_LANES-1:0]   par_lane;
   logic                     frame_clock;

   always_comb begin
      src = shreg_ff;
      if (frame_start) begin
         src = acc_full ? (acc_ff << align_sh) : '0;
      end
   end

   assign frame_clock = (bitcnt_ff < half_bit);

   genvar n;
   generate
      for (n = 0; n < `LSOF_LANES; n++) begin : g_lane
         localparam int P = `LSOF_LANES - 1 - n;
         if (n == 0) begin : g_l0
            assign ser_lane[n] = frame_clock;
         end else begin : g_ld
            assign ser_lane[n] = (5'(P) < lane_cnt) ? src[`LSOF_FRAME_W-1-P] : 1'b0;
         end
         if (n >= `LSOF_PAR_BITS) begin : g_pz
            assign par_lane[n] = 1'b0;
         end else if (n >= `LSOF_SUB_LANES) begin : g_pd
            assign par_lane[n] = fifo_valid & word[n];
         end else begin : g_ps
            // marker beats overrange, overrange beats scramble bit
            assign par_lane[n] = (n == 0 && cfg_ff.marker_en)         ? i_sample_marker  :
                                 cfg_ff.ovr_sel[n]                    ? i_overrange_flag :
                                 (cfg_ff.scr_en && cfg_ff.scr_sel[n]) ? prbs_bit         :
                                 (fifo_valid & word[n]);
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shreg_ff <= '0;
      end else if (bit_en && mode == LSOF_SER) begin
         shreg_ff <= src << lane_cnt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lane <= '0;
      end else if (bit_en) begin
         if (mode == LSOF_SER) begin
            o_lane <= ser_lane;
         end else if (frame_start) begin
            o_lane <= par_lane;
         end else if (mode == LSOF_DDR) begin
            o_lane <= '0;
         end
      end
   end

   // bit clock rises with each frame or parallel word and toggles on every bit slot
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_data_bit_clock <= 1'b0;
      end else if (bit_en) begin
         o_data_bit_clock <= (bitcnt_ff == '0) ? 1'b1 : ~o_data_bit_clock;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cfg_err  <= 1'b0;
         o_underrun <= 1'b0;
      end else begin
         o_cfg_err  <= (!cfg_ff.cplx && cfg_ff.bands_l2 != '0)
                     | ((mode == LSOF_SER) && !ge1 && !i_data_bit_clock_div_en)
                     | ((mode == LSOF_SER) && ge1 && ll2_raw > `LSOF_LANE_L2_MAX);
         o_underrun <= frame_start & ((mode == LSOF_SER) ? !acc_full : !fifo_valid);
      end
   end
endmodule

// ### tb/lsof_formatter_checker.sv
// port assertions of the lvds sample output formatter
`timescale 1ns/1ps
module lsof_formatter_checker #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic                  i_ddr_en,
   input  wire logic                  i_res32,
   input  wire lsof_pkg::lsof_bands_t i_bands_l2,
   input  wire logic                  i_complex,
   input  wire lsof_pkg::lsof_dec_t   i_dec_l2,
   input  wire logic                  i_data_bit_clock_div_en,
   input  wire logic [2:0]            i_ovr_sel,
   input  wire logic [2:0]            i_scr_sel,
   input  wire logic                  i_scr_en,
   input  wire logic                  i_marker_en,
   input  wire logic [15:0]           o_lane,
   input  wire logic                  o_data_bit_clock,
   input  wire logic                  o_cfg_err
);
   import lsof_pkg::*;
   logic [17:0] cfg_now;
   logic [17:0] cfg_ff;
   logic [7:0]  age_ff;
   logic        settled;
   logic        par;
   logic        ser1;
   assign cfg_now = {i_ddr_en, i_res32, i_bands_l2, i_complex, i_dec_l2, i_data_bit_clock_div_en,
                     i_ovr_sel, i_scr_sel, i_scr_en, i_marker_en};
   // config unchanged for 255 cycles, long enough to outlast a frame in flight up to decimation 2^6 (128-cycle frames)
   assign settled = (age_ff == 8'hff) && (cfg_now == cfg_ff);
   assign par     = settled && (i_dec_l2 == 4'h0);
   assign ser1    = settled && (i_dec_l2 == 4'h3) && !i_res32 && (i_bands_l2 == 2'h0) && !i_complex;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_ff <= '0;
         age_ff <= 8'h00;
      end else begin
         cfg_ff <= cfg_now;
         age_ff <= (cfg_now != cfg_ff) ? 8'h00 : (age_ff == 8'hff) ? age_ff : age_ff + 8'h01;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_par_top_zero: assert property (par |-> o_lane[15:14] == 2'h0)
      else $error("parallel lanes 14 and 15 not zero");
   a_ddr_fall_zero: assert property (par && i_ddr_en && !o_data_bit_clock |-> o_lane == 16'h0000)
      else $error("double-edge falling half not zero");
   a_sdr_hold: assert property (par && !i_ddr_en && $fell(o_data_bit_clock) |-> $stable(o_lane))
      else $error("single-edge data not held");
   a_par_data_bit_clock_flip: assert property (par |=> o_data_bit_clock != $past(o_data_bit_clock))
      else $error("parallel bit clock not toggling");
   a_frame_clock_shape: assert property (ser1 && $rose(o_lane[0]) |-> o_lane[0] [*8] ##1 !o_lane[0] [*8] ##1 o_lane[0])
      else $error("frame clock shape wrong");
   a_frame_clock_data_bit_clock: assert property (ser1 && $rose(o_lane[0]) |-> o_data_bit_clock ##1 !o_data_bit_clock)
      else $error("bit clock not aligned to frame");
   a_ser_lane_use: assert property (ser1 |-> o_lane[14:1] == 14'h0000)
      else $error("single lane mode drives extra lanes");
   a_real_one_band: assert property (settled && i_dec_l2 != 4'h0 && !i_complex && i_bands_l2 != 2'h0 |-> o_cfg_err)
      else $error("real multi-band not flagged");
   a_div_needed: assert property (settled && i_dec_l2 == 4'h4 && !i_res32 && !i_complex && i_bands_l2 == 2'h0
                                  |-> o_cfg_err == !i_data_bit_clock_div_en)
      else $error("divider check wrong");
   a_one_lane_ok: assert property (ser1 |-> !o_cfg_err)
      else $error("one lane config flagged");
endmodule

bind lsof_formatter lsof_formatter_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_ddr_en(i_ddr_en), .i_res32(i_res32), .i_bands_l2(i_bands_l2),
   .i_complex(i_complex), .i_dec_l2(i_dec_l2), .i_data_bit_clock_div_en(i_data_bit_clock_div_en), .i_ovr_sel(i_ovr_sel),
   .i_scr_sel(i_scr_sel), .i_scr_en(i_scr_en), .i_marker_en(i_marker_en), .o_lane(o_lane),
   .o_data_bit_clock(o_data_bit_clock), .o_cfg_err(o_cfg_err)
);

// ### tb/lsof_rx_model.sv
// receiver model: recovers single-lane serialized frames
`timescale 1ns/1ps
module lsof_rx_model (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_res32,
   input  wire logic [15:0] i_lane,
   output logic [31:0]      o_word,
   output logic             o_word_valid
);
   logic [31:0] sr_ff;
   logic        frame_clock_ff;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sr_ff   <= '0;
         frame_clock_ff <= 1'b0;
      end else begin
         sr_ff   <= {sr_ff[30:0], i_lane[15]};
         frame_clock_ff <= i_lane[0];
      end
   end
   // frame clock rise closes the frame shifted in before it
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_word       <= '0;
         o_word_valid <= 1'b0;
      end else begin
         o_word_valid <= i_lane[0] && !frame_clock_ff;
         if (i_lane[0] && !frame_clock_ff) begin
            o_word <= i_res32 ? sr_ff : {16'h0000, sr_ff[15:0]};
         end
      end
   end
endmodule

// ### tb/tb_top.sv
// testbench of the lvds sample output formatter
`timescale 1ns/1ps
module tb_top;
   import lsof_pkg::*;
   logic        clk;
   logic        nrst;
   logic [31:0] smp_data;
   logic        smp_valid;
   logic        smp_ready;
   lsof_cfg_t   cfg;
   logic        div_en;
   logic        ovr_flag;
   logic        marker;
   logic [15:0] lane;
   logic        data_bit_clock;
   logic        cfg_err;
   logic        underrun;
   logic [31:0] rx_word;
   logic        rx_valid;
   logic [15:0] hi;
   logic [15:0] lo;
   int          num_errors;
   int          checked;

   lsof_formatter #(.FIFO_DEPTH(8)) uut (
      .i_clk(clk), .i_nrst(nrst), .i_smp_data(smp_data), .i_smp_valid(smp_valid), .o_smp_ready(smp_ready),
      .i_ddr_en(cfg.ddr), .i_res32(cfg.res32), .i_bands_l2(cfg.bands_l2), .i_complex(cfg.cplx),
      .i_dec_l2(cfg.dec_l2), .i_data_bit_clock_div_en(div_en), .i_ovr_sel(cfg.ovr_sel), .i_scr_sel(cfg.scr_sel),
      .i_scr_en(cfg.scr_en), .i_marker_en(cfg.marker_en), .i_overrange_flag(ovr_flag),
      .i_sample_marker(marker), .o_lane(lane), .o_data_bit_clock(data_bit_clock), .o_cfg_err(cfg_err),
      .o_underrun(underrun)
   );
   lsof_rx_model rx (
      .i_clk(clk), .i_nrst(nrst), .i_res32(cfg.res32), .i_lane(lane), .o_word(rx_word), .o_word_valid(rx_valid)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // holds the word offered until cnt edges took it
   task automatic push(input logic [31:0] w, input int cnt);
      int k = 0;
      int n = 0;
      smp_data = w;
      smp_valid = 1'b1;
      while (k < cnt && n < 2000) begin
         @(posedge clk);
         if (smp_ready === 1'b1) k++;
         n++;
      end
      #1 smp_valid = 1'b0;
      chk(k, cnt);
   endtask
   task automatic grab;
      int n = 0;
      while (data_bit_clock !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
      chk({31'h0, data_bit_clock}, 32'h1);
      hi = lane;
      cyc(1);
      lo = lane;
   endtask
   task automatic wrx;
      int n = 0;
      cyc(1);
      while (rx_valid !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk({31'h0, rx_valid}, 32'h1);
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      int k;
      nrst = 1'b0;
      smp_data = '0;
      smp_valid = 1'b0;
      cfg = '0;
      div_en = 1'b0;
      ovr_flag = 1'b1;
      marker = 1'b0;
      num_errors = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      #1;
      chk({15'h0, lane, smp_ready}, 32'h0);
      nrst = 1'b1;
      cyc(2);
      chk({31'h0, smp_ready}, 32'h1);
      $display("test reset done");
      for (int d = 0; d < 2; d++) begin
         cfg.ddr = d[0];
         cyc(300);
         push(32'h0000_2a5c, 12);
         grab();
         chk({hi, lo}, {16'h2a5c, (d == 1) ? 16'h0000 : 16'h2a5c});
         $display("test parallel ddr=%0d done", d);
      end
      cfg.ddr = 1'b0;
      cfg.ovr_sel = 3'h7;
      cyc(300);
      push(32'h0000_2a5c, 12);
      grab();
      chk({16'h0, hi}, 32'h2a5f);
      cfg.ovr_sel = 3'h1;
      cfg.marker_en = 1'b1;
      cyc(300);
      push(32'h0000_2a5c, 12);
      grab();
      chk({16'h0, hi}, 32'h2a5c);
      cfg = '0;
      cfg.scr_en = 1'b1;
      cfg.scr_sel = 3'h4;
      cyc(300);
      push(32'h0000_2a5c, 12);
      grab();
      chk({31'h0, (hi === 16'h2a58 || hi === 16'h15a7)}, 32'h1);
      $display("test substitution done");
      cfg = '0;
      cfg.dec_l2 = 4'h3;
      cyc(300);
      push(32'h0000_b3c5, 12);
      wrx();
      wrx();
      chk(rx_word, 32'h0000_b3c5);
      chk({31'h0, cfg_err}, 32'h0);
      cfg.res32 = 1'b1;
      cfg.dec_l2 = 4'h4;
      cyc(300);
      push(32'h9e37_41d2, 12);
      cyc(2);
      chk({31'h0, smp_ready}, 32'h0);
      wrx();
      wrx();
      chk(rx_word, 32'h9e37_41d2);
      k = 0;
      while (underrun !== 1'b1 && k < 600) begin
         cyc(1);
         k++;
      end
      chk({30'h0, underrun, smp_ready}, 32'h3);
      cfg = '0;
      cfg.dec_l2 = 4'h3;
      cfg.ovr_sel = 3'h2;
      cfg.scr_en = 1'b1;
      cfg.scr_sel = 3'h4;
      cyc(300);
      push(32'h0000_b3c4, 12);
      wrx();
      wrx();
      // receiver side: scramble bit on lsb+1 undoes the xor, overrange on lsb
      chk({16'h0, rx_word[15:2] ^ {14{rx_word[1]}}, rx_word[0]}, 32'h0000_59e3);
      $display("test serial substitution done");
      $display("test serial done");
      cfg = '0;
      cfg.dec_l2 = 4'h3;
      cfg.bands_l2 = 2'h1;
      cyc(300);
      chk({31'h0, cfg_err}, 32'h1);
      cfg.bands_l2 = 2'h0;
      cfg.dec_l2 = 4'h4;
      cyc(300);
      chk({31'h0, cfg_err}, 32'h1);
      div_en = 1'b1;
      cyc(300);
      chk({31'h0, cfg_err}, 32'h0);
      div_en = 1'b0;
      cfg.cplx = 1'b1;
      cfg.bands_l2 = 2'h1;
      cfg.dec_l2 = 4'h3;
      cyc(300);
      chk({31'h0, cfg_err}, 32'h0);
      $display("test config check done");
      print_verdict();
   end

   initial begin
      #80000;
      num_errors++;
      print_verdict();
   end
endmodule
